/* rtl/flash_read_defs.svh */
// Notes on behaviour
// [R1] Fast single-line read: device latches address on rise, shifts data on fall.
// [R2] Device address advances per byte and wraps to zero after the top.
// [R3] Fast read: select low, instruction, 3-byte address, dummy byte, data until deselect.
// [R4] Device ignores reads while a program, erase or status write runs.
// [R5] Single-line double-rate: instruction 1 bit/clock, address 2 bits/clock, 6 dummy clocks.
// [R6] Double-rate single line: one bit on rise, the other on fall.
// [R7] Dual read: address on lanes 1..0 on rises, 4 dummy, two bits per fall.
// [R8] Dual double-rate: address 4 bits/clock, two per edge, 6 dummy clocks.
// [R9] Host sets quad enable before issuing the quad read.
// [R10] Quad read: address on lanes 3..0 on rises, 6 dummy, four bits per fall.
// [R11] Quad enhance: address, toggle byte, 4 dummy; next frame starts at the address.
// [R12] Complementary toggle byte nibbles keep enhance mode.
// [R13] Non-complementary toggle byte ends enhance mode; next frame needs the instruction.
// [R14] Host sets quad enable before issuing the quad double-rate read.
// [R15] Quad double-rate: address 8 bits/clock, four per edge, 8 dummy clocks.
// [R16] Quad double-rate enhance: address, toggle byte, 7 dummy clocks, later frames skip instruction.
// [R17] With quad enable set, lanes 2 and 3 carry data, not protect or hold.
// [R18] Most significant bit on the highest lane; bytes go most significant bit first.
// [R19] Device releases outputs and aborts the read when select rises.
`ifndef FLASH_READ_DEFS_SVH
`define FLASH_READ_DEFS_SVH
`define FR_QUARTER_CYC 4'h4
`define FR_INSTR_SLOTS 5'h08
`define FR_ADDR_BITS 5'h18
`define FR_ENH_BITS 5'h08
`define FR_BYTE_BITS 4'h8
`define FR_DUMMY_FAST 5'h08
`define FR_DUMMY_SDTR 5'h06
`define FR_DUMMY_DUAL 5'h04
`define FR_DUMMY_DDTR 5'h06
`define FR_DUMMY_QUAD 5'h06
`define FR_DUMMY_QUAD_ENH 5'h04
`define FR_DUMMY_QDTR 5'h08
`define FR_DUMMY_QDTR_ENH 5'h07
`define FR_ADDR_PAD 16'h0000
`define FR_IDLE_OUT 4'hC
`endif

/* rtl/flash_read_pkg.sv */
`include "flash_read_defs.svh"
package flash_read_pkg;
  typedef enum logic [2:0] {
    M_FAST = 3'b000,
    M_SINGLE_LINE_DOUBLE_RATE_READ = 3'b001,
    M_DUAL_LANE_READ = 3'b010,
    M_DUAL_LANE_DOUBLE_RATE_READ = 3'b011,
    M_QUAD_LANE_READ = 3'b100,
    M_QUAD_LANE_DOUBLE_RATE_READ = 3'b101
  } read_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_INSTR = 3'b001,
    ST_ADDR = 3'b010,
    ST_ENH = 3'b011,
    ST_DUMMY = 3'b100,
    ST_DATA = 3'b101,
    ST_END = 3'b110,
    ST_GAP = 3'b111
  } seq_state_e;

  function automatic logic [1:0] lanes_lg(input logic [2:0] m);
    lanes_lg = (m == M_QUAD_LANE_READ || m == M_QUAD_LANE_DOUBLE_RATE_READ) ? 2'h2 :
               (m == M_DUAL_LANE_READ || m == M_DUAL_LANE_DOUBLE_RATE_READ) ? 2'h1 : 2'h0;
  endfunction : lanes_lg

  function automatic logic is_dtr(input logic [2:0] m);
    is_dtr = m[0];
  endfunction : is_dtr

  function automatic logic is_quad(input logic [2:0] m);
    is_quad = (lanes_lg(m) == 2'h2);
  endfunction : is_quad

  function automatic logic [4:0] dummy_clocks(input logic [2:0] m, input logic enh);
    case (m)
      M_FAST: dummy_clocks = `FR_DUMMY_FAST;
      M_SINGLE_LINE_DOUBLE_RATE_READ: dummy_clocks = `FR_DUMMY_SDTR;
      M_DUAL_LANE_READ: dummy_clocks = `FR_DUMMY_DUAL;
      M_DUAL_LANE_DOUBLE_RATE_READ: dummy_clocks = `FR_DUMMY_DDTR;
      M_QUAD_LANE_READ: dummy_clocks = enh ? `FR_DUMMY_QUAD_ENH : `FR_DUMMY_QUAD;
      default: dummy_clocks = enh ? `FR_DUMMY_QDTR_ENH : `FR_DUMMY_QDTR;
    endcase
  endfunction : dummy_clocks

  function automatic logic keeps_enh(input logic [7:0] p);
    keeps_enh = (p[7:4] == ~p[3:0]);
  endfunction : keeps_enh
endpackage : flash_read_pkg

/* rtl/sclk_quarter_gen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_read_defs.svh"
module sclk_quarter_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  // Quarter-period events
  output logic tick,
  output logic [1:0] phase
);
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] ph_q, ph_d;

  // Parked at phase 3 so the first tick of a frame enters phase 0
  always_comb begin
    tick = run && (cnt_q == 4'h0);
    phase = ph_q + 2'h1;
    cnt_d = cnt_q;
    ph_d = ph_q;
    if (!run) begin
      cnt_d = `FR_QUARTER_CYC - 4'h1;
      ph_d = 2'h3;
    end else if (tick) begin
      cnt_d = `FR_QUARTER_CYC - 4'h1;
      ph_d = phase;
    end else begin
      cnt_d = cnt_q - 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= `FR_QUARTER_CYC - 4'h1;
      ph_q <= 2'h3;
    end else begin
      cnt_q <= cnt_d;
      ph_q <= ph_d;
    end
  end
endmodule : sclk_quarter_gen
`default_nettype wire

/* rtl/multi_io_flash_read.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_read_defs.svh"
module multi_io_flash_read import flash_read_pkg::*; #(
  // Instruction codes, values arbitrary
  parameter logic [7:0] OP_FAST = 8'h01,
  parameter logic [7:0] OP_SDTR = 8'h02,
  parameter logic [7:0] OP_DUAL = 8'h03,
  parameter logic [7:0] OP_DDTR = 8'h04,
  parameter logic [7:0] OP_QUAD = 8'h05,
  parameter logic [7:0] OP_QDTR = 8'h06
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Read request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_mode,
  input wire logic [23:0] cmd_addr,
  input wire logic [15:0] cmd_len,
  input wire logic cmd_enh,
  input wire logic [7:0] cmd_enh_byte,
  input wire logic cmd_abort,
  // Device state known to the host
  input wire logic write_cycle_active_flag,
  input wire logic quad_io_enable_bit,
  // Results
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic refused,
  output logic enh_active,
  // Flash pins
  output logic chip_select_n,
  output logic sclk,
  input wire logic [3:0] io_lane_in,
  output logic [3:0] io_lane_out,
  output logic [3:0] io_lane_oe_n
);
  seq_state_e st_q, st_d, src_st;
  logic [2:0] mode_q, mode_d, eff_mode, enh_mode_q, enh_mode_d;
  logic [23:0] sh_q, sh_d, src_sh, addr_q, addr_d;
  logic [4:0] cnt_q, cnt_d, src_cnt;
  logic [1:0] lg_q, lg_d, src_lg;
  logic [15:0] left_q, left_d;
  logic [7:0] enh_byte_q, enh_byte_d, in_q, in_d, in_sh, opcode;
  logic [3:0] bitc_q, bitc_d, bitc_n;
  logic [3:0] io_s1_q, io_s2_q, out_q, out_d, oe_n_q, oe_n_d;
  logic send_enh_q, send_enh_d, enh_q, enh_d, eff_enh, bad;
  logic cs_n_q, cs_n_d, sclk_q, sclk_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d, done_q, done_d, refused_q, refused_d;
  logic tick, drive, samp;
  logic [1:0] ph;
  int nl;

  sclk_quarter_gen u_quarter (
    .clk(clk),
    .rst(rst),
    .run(st_q != ST_IDLE),
    .tick(tick),
    .phase(ph)
  );

  // Pins come from the device's clocking, so two flops first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
    end else begin
      io_s1_q <= io_lane_in;
      io_s2_q <= io_s1_q;
    end
  end

  // An open enhance frame fixes the mode; the toggle byte must follow every time
  always_comb begin
    eff_mode = enh_q ? enh_mode_q : cmd_mode;
    eff_enh = is_quad(eff_mode) && (cmd_enh || enh_q); // [R11] [R16]
    bad = write_cycle_active_flag // [R4]
       || (is_quad(eff_mode) && !quad_io_enable_bit) // [R9] [R14]
       || (eff_mode > M_QUAD_LANE_DOUBLE_RATE_READ);
    case (eff_mode)
      M_FAST: opcode = OP_FAST;
      M_SINGLE_LINE_DOUBLE_RATE_READ: opcode = OP_SDTR;
      M_DUAL_LANE_READ: opcode = OP_DUAL;
      M_DUAL_LANE_DOUBLE_RATE_READ: opcode = OP_DDTR;
      M_QUAD_LANE_READ: opcode = OP_QUAD;
      default: opcode = OP_QDTR;
    endcase
  end

  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    enh_mode_d = enh_mode_q;
    sh_d = sh_q;
    addr_d = addr_q;
    cnt_d = cnt_q;
    lg_d = lg_q;
    left_d = left_q;
    enh_byte_d = enh_byte_q;
    in_d = in_q;
    bitc_d = bitc_q;
    out_d = out_q;
    oe_n_d = oe_n_q;
    send_enh_d = send_enh_q;
    enh_d = enh_q;
    cs_n_d = cs_n_q;
    sclk_d = sclk_q;
    rd_data_d = rd_data_q;
    rd_valid_d = 1'b0;
    done_d = 1'b0;
    refused_d = 1'b0;
    src_st = st_q;
    src_sh = sh_q;
    src_cnt = cnt_q;
    src_lg = lg_q;
    nl = 1;
    // Host launches at mid-low, and also mid-high for double-rate address
    drive = tick && (ph == 2'h0 || (is_dtr(mode_q) && ph == 2'h2
            && (st_q == ST_ADDR || st_q == ST_ENH))); // [R6] [R8] [R15]
    // Single-rate data is taken at the rise, double-rate after each edge
    samp = tick && st_q == ST_DATA && (is_dtr(mode_q) ? (ph == 2'h0 || ph == 2'h2)
            : (ph == 2'h1)); // [R1] [R5] [R6]
    case (lg_q)
      2'h0: in_sh = {in_q[6:0], io_s2_q[1]};
      2'h1: in_sh = {in_q[5:0], io_s2_q[1:0]};
      default: in_sh = {in_q[3:0], io_s2_q[3:0]}; // [R18]
    endcase
    bitc_n = bitc_q + 4'(1 << lg_q);
    if (tick) begin
      sclk_d = (ph == 2'h1) || (ph == 2'h2);
    end
    case (st_q)
      ST_IDLE: begin
        sclk_d = 1'b0;
        out_d = `FR_IDLE_OUT;
        // Lanes 2 and 3 stay high as protect and hold unless quad is on
        oe_n_d = {{2{quad_io_enable_bit}}, 2'b11}; // [R17]
        if (cmd_valid) begin
          if (bad) begin
            refused_d = 1'b1;
          end else begin
            mode_d = eff_mode;
            send_enh_d = eff_enh;
            enh_byte_d = cmd_enh_byte;
            addr_d = cmd_addr;
            left_d = cmd_len;
            cs_n_d = 1'b0; // [R3]
            if (enh_q) begin
              st_d = ST_ADDR; // [R11] [R16]
              sh_d = cmd_addr;
              lg_d = lanes_lg(eff_mode);
              cnt_d = `FR_ADDR_BITS >> lanes_lg(eff_mode);
            end else begin
              st_d = ST_INSTR; // [R3] [R5] [R8] [R15]
              sh_d = {opcode, `FR_ADDR_PAD};
              lg_d = 2'h0;
              cnt_d = `FR_INSTR_SLOTS;
            end
          end
        end
      end
      ST_INSTR, ST_ADDR, ST_ENH: begin
        if (cmd_abort) begin
          st_d = ST_END; // [R19]
        end else if (drive) begin
          if (cnt_q == 5'h00) begin
            if (st_q == ST_INSTR) begin
              src_st = ST_ADDR; // [R7] [R10]
              src_sh = addr_q;
              src_lg = lanes_lg(mode_q);
              src_cnt = `FR_ADDR_BITS >> src_lg;
            end else if (st_q == ST_ADDR && send_enh_q) begin
              src_st = ST_ENH; // [R11] [R16]
              src_sh = {enh_byte_q, `FR_ADDR_PAD};
              src_cnt = `FR_ENH_BITS >> src_lg;
            end else begin
              src_st = ST_DUMMY;
              src_cnt = dummy_clocks(mode_q, send_enh_q) - 5'h01; // [R3] [R5] [R7] [R10]
            end
            if (st_q == ST_ENH) begin
              enh_d = keeps_enh(enh_byte_q); // [R12] [R13]
              enh_mode_d = mode_q;
            end
          end
          st_d = src_st;
          lg_d = src_lg;
          nl = 1 << src_lg;
          if (src_st == ST_DUMMY) begin
            cnt_d = src_cnt;
            for (int i = 0; i < 4; i++) begin
              if (i < nl && src_lg != 2'h0) oe_n_d[i] = 1'b1;
            end
            if (src_lg == 2'h0) out_d[0] = 1'b0;
          end else begin
            // Top bits of the field, highest bit on the highest lane
            for (int i = 0; i < 4; i++) begin
              if (i < nl) begin
                out_d[i] = src_sh[24 - nl + i]; // [R18]
                oe_n_d[i] = 1'b0;
              end
            end
            sh_d = src_sh << nl;
            cnt_d = src_cnt - 5'h01;
          end
        end
      end
      ST_DUMMY: begin
        if (cmd_abort) begin
          st_d = ST_END; // [R19]
        end else if (tick && ph == 2'h0) begin
          if (cnt_q != 5'h00) begin
            cnt_d = cnt_q - 5'h01;
          end else begin
            st_d = ST_DATA;
            bitc_d = 4'h0;
          end
        end
      end
      ST_DATA: begin
        if (cmd_abort) begin
          st_d = ST_END; // [R3] [R19]
        end else if (samp) begin
          if (bitc_n == `FR_BYTE_BITS) begin
            rd_data_d = in_sh;
            rd_valid_d = 1'b1;
            bitc_d = 4'h0;
            addr_d = addr_q + 24'h000001; // [R2]
            if (left_q == 16'h0001) st_d = ST_END;
            if (left_q != 16'h0000) left_d = left_q - 16'h0001;
          end else begin
            bitc_d = bitc_n;
          end
          in_d = in_sh;
        end
      end
      ST_END: begin
        // Finish a started high phase, but never begin a new clock
        if (tick) sclk_d = sclk_q && (ph == 2'h2); // [R19]
        if (tick && ph == 2'h0) begin
          cs_n_d = 1'b1; // [R19]
          out_d = `FR_IDLE_OUT;
          oe_n_d = {{2{quad_io_enable_bit}}, 2'b11};
          st_d = ST_GAP;
        end
      end
      ST_GAP: begin
        sclk_d = 1'b0;
        if (tick) begin
          st_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      mode_q <= 3'h0;
      enh_mode_q <= 3'h0;
      sh_q <= 24'h000000;
      addr_q <= 24'h000000;
      cnt_q <= 5'h00;
      lg_q <= 2'h0;
      left_q <= 16'h0000;
      enh_byte_q <= 8'h00;
      in_q <= 8'h00;
      bitc_q <= 4'h0;
      out_q <= 4'h0;
      oe_n_q <= 4'hF;
      send_enh_q <= 1'b0;
      enh_q <= 1'b0;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      enh_mode_q <= enh_mode_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
      lg_q <= lg_d;
      left_q <= left_d;
      enh_byte_q <= enh_byte_d;
      in_q <= in_d;
      bitc_q <= bitc_d;
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      send_enh_q <= send_enh_d;
      enh_q <= enh_d;
      cs_n_q <= cs_n_d;
      sclk_q <= sclk_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      done_q <= done_d;
      refused_q <= refused_d;
    end
  end

  assign cmd_ready = (st_q == ST_IDLE);
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign done = done_q;
  assign refused = refused_q;
  assign enh_active = enh_q;
  assign chip_select_n = cs_n_q;
  assign sclk = sclk_q;
  assign io_lane_out = out_q;
  assign io_lane_oe_n = oe_n_q;
endmodule : multi_io_flash_read
`default_nettype wire

/* test/flash_read_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_read_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [2:0] cmd_mode,
  input wire logic write_cycle_active_flag,
  input wire logic quad_io_enable_bit,
  // Results
  input wire logic done,
  input wire logic refused,
  input wire logic enh_active,
  // Flash pins
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic [3:0] io_lane_out,
  input wire logic [3:0] io_lane_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic take;
  assign take = cmd_valid && cmd_ready && !enh_active;
  sequence s_lead;
    !sclk [*8] ##1 sclk;
  endsequence
  sequence s_high;
    sclk [*8] ##1 !sclk;
  endsequence
  AST_START: assert property (take && !write_cycle_active_flag && cmd_mode < 3'h6 &&
    (!cmd_mode[2] || quad_io_enable_bit) |=> !chip_select_n) else $error("frame not opened");
  AST_BUSY: assert property (
    cmd_valid && cmd_ready && write_cycle_active_flag |=> refused && chip_select_n)
    else $error("read not refused while busy");
  AST_QUAD_OFF: assert property (take && cmd_mode[2] && !quad_io_enable_bit |=> refused)
    else $error("quad read not refused");
  AST_LEAD: assert property ($fell(chip_select_n) |-> s_lead)
    else $error("first clock edge misplaced");
  AST_HIGH: assert property ($rose(sclk) |-> s_high)
    else $error("clock high time wrong");
  AST_HOLD: assert property ($changed(sclk) |-> $stable(io_lane_out))
    else $error("lanes change on a clock edge");
  AST_IDLE: assert property (cmd_ready |-> chip_select_n && !sclk)
    else $error("idle with select low");
  AST_DONE: assert property (done |-> cmd_ready && chip_select_n)
    else $error("done before select high");
  AST_REL: assert property (chip_select_n |-> io_lane_oe_n[1:0] == 2'h3)
    else $error("lanes driven while deselected");
endmodule : flash_read_properties
bind multi_io_flash_read flash_read_properties i_flash_read_properties (.clk, .rst,
  .cmd_valid, .cmd_ready, .cmd_mode, .write_cycle_active_flag, .quad_io_enable_bit,
  .done, .refused, .enh_active, .chip_select_n, .sclk, .io_lane_out, .io_lane_oe_n);
`default_nettype wire

/* test/flash_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
  // Flash pins
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic [3:0] pin,
  output logic [3:0] dout,
  output logic [3:0] doe,
  // Status
  input wire logic busy,
  input wire logic quad_en
);
  logic [31:0] v;
  logic [23:0] a;
  logic [7:0] y;
  logic [2:0] m;
  logic enh;
  int l;
  int dn;
  bit ddr;
  int dt[6] = '{8, 6, 4, 6, 6, 8};
  function automatic logic [7:0] mem(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'hC3;
  endfunction : mem
  task automatic rx(input int n);
    v = 32'h0;
    for (int j = 0; j < n / l; j++) begin
      if (ddr && j[0]) @(negedge sclk);
      else @(posedge sclk);
      v = (v << l) | 32'(pin & 4'((1 << l) - 1));
    end
  endtask : rx
  task automatic frame();
    if (!enh) begin
      l = 1;
      ddr = 1'b0;
      rx(8);
      m = 3'(v[7:0] - 8'h01);
    end
    if (busy || m > 3'h5 || (m[2] && !quad_en)) return;
    l = m[2] ? 4 : m[1] ? 2 : 1;
    ddr = m[0];
    rx(24);
    a = v[23:0];
    dn = dt[m];
    if (m[2]) begin
      // Plain quad frames leave lanes floating, so the byte reads FFh
      rx(8);
      enh = (v[7:4] == ~v[3:0]);
      dn = dn - (ddr ? 1 : 2);
    end
    repeat (dn) @(posedge sclk);
    for (int k = 0; k >= 0; k++) begin
      if (ddr && !k[0]) @(posedge sclk);
      else @(negedge sclk);
      if (k % (8 / l) == 0) y = mem(a);
      doe = (l == 1) ? 4'h2 : 4'((1 << l) - 1);
      dout = (l == 1) ? {2'h0, y[7 - k % 8], 1'h0} : 4'(y >> (8 - l * (k % (8 / l) + 1)));
      if (k % (8 / l) == 8 / l - 1) a = a + 24'h000001;
    end
  endtask : frame
  initial begin
    doe = 4'h0;
    dout = 4'h0;
    enh = 1'b0;
    forever begin
      @(negedge chip_select_n);
      fork : f_frame
        frame();
        @(posedge chip_select_n);
      join_any
      disable f_frame;
      doe = 4'h0;
    end
  end
endmodule : flash_dev_model
`default_nettype wire

/* test/multi_io_flash_read_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module multi_io_flash_read_bench;
  logic clk, rst, cmd_valid, cmd_ready, cmd_enh, cmd_abort, write_cycle_active_flag;
  logic quad_io_enable_bit, rd_valid, done, refused, enh_active, chip_select_n, sclk;
  logic [2:0] cmd_mode;
  logic [23:0] cmd_addr;
  logic [15:0] cmd_len;
  logic [7:0] cmd_enh_byte, rd_data;
  logic [3:0] io_lane_in, io_lane_out, io_lane_oe_n, dev_out, dev_oe;
  logic [7:0] q[$];
  int err_total = 0;
  int comparisons = 0;
  int seed = 69934;
  logic [7:0] tb[8] = '{8'hA5, 8'h5A, 8'hF0, 8'h0F, 8'hFF, 8'h00, 8'hAA, 8'h55};
  // Released lanes float high through pull-ups
  assign io_lane_in = (~io_lane_oe_n & io_lane_out) | (io_lane_oe_n & dev_oe & dev_out) |
    (io_lane_oe_n & ~dev_oe);
  multi_io_flash_read i_multi_io_flash_read (.clk, .rst, .cmd_valid, .cmd_ready, .cmd_mode,
    .cmd_addr, .cmd_len, .cmd_enh, .cmd_enh_byte, .cmd_abort, .write_cycle_active_flag,
    .quad_io_enable_bit, .rd_data, .rd_valid, .done, .refused, .enh_active, .chip_select_n,
    .sclk, .io_lane_in, .io_lane_out, .io_lane_oe_n);
  flash_dev_model i_flash_dev_model (.chip_select_n, .sclk, .pin(io_lane_in), .dout(dev_out),
    .doe(dev_oe), .busy(write_cycle_active_flag), .quad_en(quad_io_enable_bit));
  always #2.5 clk = ~clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic rd(input logic [2:0] m, input logic [23:0] a, input logic [15:0] n,
    input logic e, input logic [7:0] b);
    int t;
    for (int i = 0; i < ((n == 16'h0000) ? 200 : n); i++) begin
      q.push_back(i_flash_dev_model.mem(a + 24'(i)));
    end
    cmd_mode = m;
    cmd_addr = a;
    cmd_len = n;
    cmd_enh = e;
    cmd_enh_byte = b;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 30000) begin
      cmd_abort = (n == 16'h0000 && t > 1500);
      @(negedge clk);
      t++;
    end
    cmd_abort = 1'b0;
    if (t >= 30000) err_total++;
    chk(32'(chip_select_n), 32'h1);
    if (n == 16'h0000) begin
      chk(32'(dev_oe), 32'h0);
      q.delete();
    end
    else chk(32'(q.size()), 32'h0);
  endtask : rd
  task automatic rf(input logic [2:0] m, input logic w, input logic e);
    write_cycle_active_flag = w;
    quad_io_enable_bit = e;
    cmd_mode = m;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    chk(32'({refused, chip_select_n}), 32'h3);
    // Idle cycle so the next request never rises where this one fell
    @(negedge clk);
  endtask : rf
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (q.size() > 0) chk(32'(rd_data), 32'(q.pop_front()));
      else chk(32'(rd_data), 32'h100);
    end
  end
  initial begin
    #200000;
    err_total++;
    close_out();
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {cmd_valid, cmd_enh, cmd_abort, write_cycle_active_flag} = 4'h0;
    quad_io_enable_bit = 1'b1;
    cmd_mode = 3'h0;
    cmd_addr = 24'h000000;
    cmd_len = 16'h0000;
    cmd_enh_byte = 8'h00;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    rd(3'h0, 24'hFFFFFE, 16'h0003, 1'b0, 8'h00);
    for (int m = 0; m < 6; m++) begin
      rd(3'(m), 24'($random(seed)), 16'h0004, 1'b0, 8'h00);
    end
    for (int m = 4; m < 6; m++) begin
      for (int i = 0; i < 8; i++) begin
        rd(3'(m), 24'($random(seed)), 16'h0002, 1'b1, tb[i]);
        chk(32'(enh_active), (i < 4) ? 32'h1 : 32'h0);
      end
    end
    rd(3'h1, 24'($random(seed)), 16'h0002, 1'b0, 8'h00);
    rf(3'h0, 1'b1, 1'b1);
    rf(3'h4, 1'b0, 1'b0);
    rf(3'h5, 1'b0, 1'b0);
    rf(3'h6, 1'b0, 1'b1);
    rf(3'h7, 1'b0, 1'b1);
    rd(3'h0, 24'($random(seed)), 16'h0000, 1'b0, 8'h00);
    rd(3'h5, 24'($random(seed)), 16'h0000, 1'b0, 8'h00);
    close_out();
  end
endmodule : multi_io_flash_read_bench
`default_nettype wire
